// File: core/snr_fast_read.sv
// multi-line fast-read engine of a serial nand device, sampled on the system clock
// Operation
// - 6Ch streams each byte over four lines
// - BBh moves address, dummy, data on two lines
// - BCh uses the same two-line transfer
// - EBh moves address and data on four lines
// - ECh uses the same four-line transfer
// - buffer mode starts at received column address
// - buffer mode floats outputs after last byte
// - sequential mode starts at buffer byte zero
// - sequential mode continues into the next page
// - write-protect mode refuses all quad instructions
// - data shifts out on falling edges, msb first
// - column pointer increments after every byte, except in sequential mode where it returns to zero after the last buffer byte
`timescale 1ns/1ps
`default_nettype none

module snr_fast_read (
  input  wire  logic        i_sys_clk,
  input  wire  logic        i_reset_n,
  input  wire  logic        i_spi_clk,
  input  wire  logic        i_cs_n,
  input  wire  logic [3:0]  i_io,
  output logic       [3:0]  o_io,
  output logic       [3:0]  o_io_oe,
  input  wire  logic        i_buf_mode,
  input  wire  logic        i_wp_mode,
  output logic       [11:0] o_rd_col,
  input  wire  logic [7:0]  i_rd_data,
  output logic              o_page_inc
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic               s1_clk;
    logic               s2_clk;
    logic               s3_clk;
    logic               s1_cs;
    logic               s2_cs;
    logic [3:0]         s1_io;
    logic [3:0]         s2_io;
    snr_pkg::snr_state_t st;
    logic [7:0]         op;
    logic [2:0]         alanes;
    logic [2:0]         dlanes;
    logic [5:0]         dum;
    logic [5:0]         cnt;
    logic [15:0]        col;
    logic [7:0]         sh;
    logic [2:0]         bcnt;
    logic [3:0]         io_out;
    logic [3:0]         io_oe;
    logic               page_inc;
  } snr_regs_t;

  snr_regs_t r;
  snr_regs_t next_r;

  logic       rise;
  logic       fall;
  logic       cs_act;
  logic [7:0] op_full;
  logic [5:0] addr_last;
  logic       load;
  logic [3:0] first_bits;

  assign rise    = r.s2_clk & ~r.s3_clk;
  assign fall    = ~r.s2_clk & r.s3_clk;
  assign cs_act  = ~r.s2_cs;
  assign op_full = {r.op[6:0], r.s2_io[0]};
  assign load    = (r.st == snr_pkg::ST_DATA) && cs_act && fall && (r.bcnt == 3'h0);
  // msb of the byte goes out first on the widest lanes in use
  assign first_bits = (r.dlanes == snr_pkg::LANE_4) ? i_rd_data[7:4]
                                                     : {2'h0, i_rd_data[7:6]};

  always_comb begin
    case (r.alanes)
      snr_pkg::LANE_1: addr_last = snr_pkg::ADDR_LAST_1;
      snr_pkg::LANE_2: addr_last = snr_pkg::ADDR_LAST_2;
      default:         addr_last = snr_pkg::ADDR_LAST_4;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r          = r;
    next_r.s1_clk   = i_spi_clk;
    next_r.s2_clk   = r.s1_clk;
    next_r.s3_clk   = r.s2_clk;
    next_r.s1_cs    = i_cs_n;
    next_r.s2_cs    = r.s1_cs;
    next_r.s1_io    = i_io;
    next_r.s2_io    = r.s1_io;
    next_r.page_inc = 1'b0;
    if (!cs_act) begin
      // a raised select ends any read and frees the lines at once
      next_r.st    = snr_pkg::ST_IDLE;
      next_r.io_oe = 4'h0;
      next_r.cnt   = 6'h00;
    end else begin
      case (r.st)
        snr_pkg::ST_IDLE: begin
          next_r.st  = snr_pkg::ST_CMD;
          next_r.cnt = 6'h00;
          if (rise) begin
            next_r.op  = {r.op[6:0], r.s2_io[0]};
            next_r.cnt = 6'h01;
          end
        end
        snr_pkg::ST_CMD: begin
          if (rise) begin
            next_r.op  = op_full;
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == snr_pkg::CMD_LAST) begin
              next_r.cnt = 6'h00;
              next_r.col = snr_pkg::COL_FIRST;
              next_r.st  = snr_pkg::ST_ADDR;
              case (op_full)
                snr_pkg::OP_QUAD_OUT4: begin
                  next_r.alanes = snr_pkg::LANE_1;
                  next_r.dlanes = snr_pkg::LANE_4;
                  next_r.dum    = i_buf_mode ? snr_pkg::DUM_QO4_BUF : snr_pkg::DUM_QO4_SEQ;
                end
                snr_pkg::OP_DUAL_IO: begin
                  next_r.alanes = snr_pkg::LANE_2;
                  next_r.dlanes = snr_pkg::LANE_2;
                  next_r.dum    = snr_pkg::DUM_DIO;
                end
                snr_pkg::OP_DUAL_IO4: begin
                  next_r.alanes = snr_pkg::LANE_2;
                  next_r.dlanes = snr_pkg::LANE_2;
                  next_r.dum    = i_buf_mode ? snr_pkg::DUM_DIO4_BUF : snr_pkg::DUM_DIO4_SEQ;
                end
                snr_pkg::OP_QUAD_IO: begin
                  next_r.alanes = snr_pkg::LANE_4;
                  next_r.dlanes = snr_pkg::LANE_4;
                  next_r.dum    = snr_pkg::DUM_QIO;
                end
                snr_pkg::OP_QUAD_IO4: begin
                  next_r.alanes = snr_pkg::LANE_4;
                  next_r.dlanes = snr_pkg::LANE_4;
                  next_r.dum    = i_buf_mode ? snr_pkg::DUM_QIO4_BUF : snr_pkg::DUM_QIO4_SEQ;
                end
                default: begin
                  // other instructions belong to other paths; stay off the lines
                  next_r.st = snr_pkg::ST_HIZ;
                end
              endcase
              if (i_wp_mode && (op_full == snr_pkg::OP_QUAD_OUT4 ||
                                op_full == snr_pkg::OP_QUAD_IO ||
                                op_full == snr_pkg::OP_QUAD_IO4)) begin
                next_r.st = snr_pkg::ST_HIZ;
              end
            end
          end
        end
        snr_pkg::ST_ADDR: begin
          if (rise) begin
            case (r.alanes)
              snr_pkg::LANE_1: next_r.col = {r.col[14:0], r.s2_io[0]};
              snr_pkg::LANE_2: next_r.col = {r.col[13:0], r.s2_io[1:0]};
              default:         next_r.col = {r.col[11:0], r.s2_io[3:0]};
            endcase
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == addr_last) begin
              next_r.cnt = 6'h00;
              next_r.st  = snr_pkg::ST_DUMMY;
            end
          end
        end
        snr_pkg::ST_DUMMY: begin
          if (rise) begin
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == r.dum - 6'h01) begin
              next_r.cnt  = 6'h00;
              next_r.bcnt = 3'h0;
              next_r.st   = snr_pkg::ST_DATA;
              if (!i_buf_mode) begin
                next_r.col = snr_pkg::COL_FIRST;
              end
            end
          end
        end
        snr_pkg::ST_DATA: begin
          if (fall) begin
            if (r.bcnt == 3'h0) begin
              if (i_buf_mode && (r.col > snr_pkg::BUF_LAST)) begin
                next_r.st    = snr_pkg::ST_HIZ;
                next_r.io_oe = 4'h0;
              end else begin
                // lines are driven only once the host has let go of them
                next_r.io_oe  = (r.dlanes == snr_pkg::LANE_4) ? 4'hF : 4'h3;
                next_r.io_out = first_bits;
                next_r.sh     = (r.dlanes == snr_pkg::LANE_4) ? {i_rd_data[3:0], 4'h0}
                                                               : {i_rd_data[5:0], 2'h0};
                next_r.bcnt   = (r.dlanes == snr_pkg::LANE_4) ? 3'h1 : 3'h3;
                next_r.col    = r.col + 16'h0001;
                if (!i_buf_mode && (r.col == snr_pkg::BUF_LAST)) begin
                  next_r.col      = snr_pkg::COL_FIRST;
                  next_r.page_inc = 1'b1;
                end
              end
            end else begin
              next_r.bcnt = r.bcnt - 3'h1;
              if (r.dlanes == snr_pkg::LANE_4) begin
                next_r.io_out = r.sh[7:4];
                next_r.sh     = {r.sh[3:0], 4'h0};
              end else begin
                next_r.io_out = {2'h0, r.sh[7:6]};
                next_r.sh     = {r.sh[5:0], 2'h0};
              end
            end
          end
        end
        snr_pkg::ST_HIZ: begin
          next_r.io_oe = 4'h0;
        end
        default: begin
          next_r.st = snr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      r          <= '0;
      r.s1_clk   <= 1'b0;
      r.s1_cs    <= 1'b1;
      r.s2_cs    <= 1'b1;
      r.st       <= snr_pkg::ST_IDLE;
      r.alanes   <= snr_pkg::LANE_1;
      r.dlanes   <= snr_pkg::LANE_4;
    end else begin
      r <= next_r;
    end
  end

  assign o_io       = r.io_out;
  assign o_io_oe    = r.io_oe;
  assign o_rd_col   = r.col[11:0];
  assign o_page_inc = r.page_inc;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_cs_release: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !cs_act |=> (o_io_oe == 4'h0))
    else $error("lines driven while select is high");

  a_wp_refuse: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (cs_act && r.st == snr_pkg::ST_CMD && rise && r.cnt == snr_pkg::CMD_LAST && i_wp_mode &&
     (op_full == snr_pkg::OP_QUAD_IO || op_full == snr_pkg::OP_QUAD_IO4 ||
      op_full == snr_pkg::OP_QUAD_OUT4)) |=> (r.st == snr_pkg::ST_HIZ) ##1 (o_io_oe == 4'h0))
    else $error("quad read not refused under write protect");

  a_quad_lanes: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (o_io_oe != 4'h0 && r.dlanes == snr_pkg::LANE_4) |-> (o_io_oe == 4'hF))
    else $error("quad data not on four lines");

  a_dual_lanes: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (o_io_oe != 4'h0 && r.dlanes == snr_pkg::LANE_2) |-> (o_io_oe == 4'h3))
    else $error("dual data not on two lines");

  a_seq_start: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (r.st == snr_pkg::ST_DUMMY && next_r.st == snr_pkg::ST_DATA && !i_buf_mode)
      |=> (r.col == snr_pkg::COL_FIRST))
    else $error("sequential read not started at byte zero");

  a_buf_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (r.st == snr_pkg::ST_DUMMY && next_r.st == snr_pkg::ST_DATA && i_buf_mode)
      |=> $stable(r.col))
    else $error("buffer read lost its column address");

  a_buf_end: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (load && i_buf_mode && r.col > snr_pkg::BUF_LAST) |=> (o_io_oe == 4'h0) [*2])
    else $error("lines not floated after last buffer byte");

  a_page_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (load && !i_buf_mode && r.col == snr_pkg::BUF_LAST)
      |=> (o_page_inc && r.col == snr_pkg::COL_FIRST) ##1 !o_page_inc)
    else $error("sequential read did not roll into the next page");

  a_ptr_step: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (load && r.col < snr_pkg::BUF_LAST) |=> (r.col == $past(r.col) + 16'h0001))
    else $error("column pointer did not step after a byte");

  a_msb_first: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (load && !(i_buf_mode && r.col > snr_pkg::BUF_LAST)) |=>
      (o_io == ((r.dlanes == snr_pkg::LANE_4) ? $past(i_rd_data[7:4])
                                              : {2'h0, $past(i_rd_data[7:6])})))
    else $error("byte not started with its top bits");

  c_quad_io: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    load && r.op == snr_pkg::OP_QUAD_IO);
  c_dual_io4: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    load && r.op == snr_pkg::OP_DUAL_IO4);
  c_buf_end: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    load && i_buf_mode && r.col > snr_pkg::BUF_LAST);
  c_wrap: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    o_page_inc);

endmodule // snr_fast_read

`default_nettype wire

// File: core/snr_pkg.sv
// constants and types for the serial nand multi-line fast-read path
package snr_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // instruction codes
  localparam logic [7:0] OP_QUAD_OUT4  = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO4   = 8'hBC;
  localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO4   = 8'hEC;

  //////////////////////////////////////////////////////////////////////////////
  // lane counts, phase lengths in link clocks
  localparam logic [2:0] LANE_1        = 3'h1;
  localparam logic [2:0] LANE_2        = 3'h2;
  localparam logic [2:0] LANE_4        = 3'h4;
  localparam logic [5:0] CMD_LAST      = 6'h07;
  localparam logic [5:0] ADDR_LAST_1   = 6'h0F;
  localparam logic [5:0] ADDR_LAST_2   = 6'h07;
  localparam logic [5:0] ADDR_LAST_4   = 6'h03;
  localparam logic [5:0] DUM_QO4_BUF   = 6'h18;
  localparam logic [5:0] DUM_QO4_SEQ   = 6'h28;
  localparam logic [5:0] DUM_DIO       = 6'h04;
  localparam logic [5:0] DUM_DIO4_BUF  = 6'h0C;
  localparam logic [5:0] DUM_DIO4_SEQ  = 6'h14;
  localparam logic [5:0] DUM_QIO       = 6'h04;
  localparam logic [5:0] DUM_QIO4_BUF  = 6'h06;
  localparam logic [5:0] DUM_QIO4_SEQ  = 6'h0A;

  //////////////////////////////////////////////////////////////////////////////
  // data buffer geometry
  localparam logic [15:0] BUF_LAST     = 16'h087F;
  localparam logic [15:0] COL_FIRST    = 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // transaction states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CMD   = 6'h02,
    ST_ADDR  = 6'h04,
    ST_DUMMY = 6'h08,
    ST_DATA  = 6'h10,
    ST_HIZ   = 6'h20
  } snr_state_t;

endpackage

// File: tb/snr_host_model.sv
// host-side spi controller model issuing dual and quad fast reads
`timescale 1ns/1ps
`default_nettype none

module snr_host_model (
  input  wire  logic       i_sys_clk,
  input  wire  logic [3:0] i_io,
  input  wire  logic [3:0] i_dev_oe,
  output logic             o_spi_clk,
  output logic             o_cs_n,
  output logic       [3:0] o_io,
  output logic       [3:0] o_io_oe
);
  logic [7:0] got[$];
  logic [3:0] got_oe[$];

  // i_dev_oe is a bench probe only, a real host cannot see it
  initial begin
    o_spi_clk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
    o_io_oe = 4'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode 0: bits change while the clock is low, clock idles low outside frames
  task automatic tick(input logic [3:0] v, input logic [3:0] oe);
    o_io = v;
    o_io_oe = oe;
    #16 o_spi_clk = 1'b1;
    #16 o_spi_clk = 1'b0;
  endtask

  task automatic rd(input logic [7:0] op, input logic [15:0] col, input int al, input int dl,
                    input int nd, input int nb);
    logic [7:0] b;
    logic [3:0] am;
    am = 4'((1 << al) - 1);
    got.delete();
    got_oe.delete();
    @(posedge i_sys_clk);
    #1 o_cs_n = 1'b0;
    #16;
    for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, 4'h1);
    for (int i = 16 - al; i >= 0; i -= al) tick(4'(col >> i) & am, am);
    repeat (nd) tick(4'h0, am);
    o_io_oe = 4'h0;
    repeat (nb) begin
      b = 8'h00;
      // sample late in the high half, off the system clock edge that launches outputs
      for (int j = 0; j < 8 / dl; j++) begin
        #16 o_spi_clk = 1'b1;
        #14 b = 8'((b << dl) | (i_io & 4'((1 << dl) - 1)));
        if (j == 0) got_oe.push_back(i_dev_oe);
        #2 o_spi_clk = 1'b0;
      end
      got.push_back(b);
    end
    #16 o_cs_n = 1'b1;
    #48;
  endtask
endmodule // snr_host_model

`default_nettype wire

// File: tb/snr_fast_read_test.sv
// self-checking bench of the multi-line fast-read engine
`timescale 1ns/1ps
`default_nettype none

module snr_fast_read_test;
  logic        sys_clk, reset_n, spi_clk, cs_n, buf_mode, wp_mode, page_inc, flip;
  logic [3:0]  dev_io, dev_oe, host_io, host_oe, io_w;
  logic [11:0] rd_col;
  logic [7:0]  rd_data;
  logic [31:0] rnd;
  int          pages, n_mismatch, check_count;
  logic [7:0]  ops [5] = '{snr_pkg::OP_QUAD_OUT4, snr_pkg::OP_DUAL_IO, snr_pkg::OP_DUAL_IO4,
                           snr_pkg::OP_QUAD_IO, snr_pkg::OP_QUAD_IO4};

  // released lines wander so a stale level never passes for data
  assign io_w = (dev_oe & dev_io) | (~dev_oe & host_oe & host_io) |
                (~dev_oe & ~host_oe & {4{flip}});

  function automatic logic [7:0] mem(input int c, input int p);
    return 8'((c ^ (c >> 4) ^ (p * 29)) & 255);
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  assign rd_data = mem(int'(rd_col), pages);

  snr_fast_read snr_fast_read_i (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_spi_clk(spi_clk),
    .i_cs_n(cs_n), .i_io(io_w), .o_io(dev_io), .o_io_oe(dev_oe), .i_buf_mode(buf_mode),
    .i_wp_mode(wp_mode), .o_rd_col(rd_col), .i_rd_data(rd_data), .o_page_inc(page_inc));
  snr_host_model snr_host_model_i (.i_sys_clk(sys_clk), .i_io(io_w), .i_dev_oe(dev_oe),
    .o_spi_clk(spi_clk), .o_cs_n(cs_n), .o_io(host_io), .o_io_oe(host_oe));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    flip <= ~flip;
    if (page_inc === 1'b1) pages <= pages + 1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic run(input logic [7:0] op, input logic bm, input logic wp, input int col,
                     input int n);
    int al, dl, nd, c, p, pg0;
    al = 4;
    dl = 4;
    case (op)
      snr_pkg::OP_QUAD_OUT4: begin al = 1; nd = bm ? 24 : 40; end
      snr_pkg::OP_DUAL_IO:   begin al = 2; dl = 2; nd = 4; end
      snr_pkg::OP_DUAL_IO4:  begin al = 2; dl = 2; nd = bm ? 12 : 20; end
      snr_pkg::OP_QUAD_IO:   nd = 4;
      default:               nd = bm ? 6 : 10;
    endcase
    @(posedge sys_clk);
    #1 buf_mode = bm;
    wp_mode = wp;
    pg0 = pages;
    snr_host_model_i.rd(op, 16'(col), al, dl, nd, n);
    for (int i = 0; i < n; i++) begin
      c = bm ? col + i : i;
      p = pg0 + c / 2176;
      c = c % 2176;
      if ((wp && dl == 4) || (bm && col + i > 2175)) begin
        chk(8'(snr_host_model_i.got_oe[i]), 8'h00);
      end else begin
        chk(8'(snr_host_model_i.got_oe[i]), dl == 4 ? 8'h0F : 8'h03);
        chk(snr_host_model_i.got[i], mem(c, p));
      end
    end
  endtask

  initial begin
    reset_n = 1'b0;
    buf_mode = 1'b1;
    wp_mode = 1'b0;
    flip = 1'b0;
    pages = 0;
    n_mismatch = 0;
    check_count = 0;
    rnd = 32'h700DF1F4;
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    chk({dev_oe, dev_io}, 8'h00);
    chk({page_inc, 7'h00}, 8'h00);
    // every opcode in both modes, with and without write protection
    for (int w = 0; w < 2; w++) begin
      for (int b = 0; b < 2; b++) begin
        foreach (ops[k]) begin
          rnd = lfsr(rnd);
          run(ops[k], b[0], w[0], int'(rnd % 2170), 3);
        end
      end
    end
    run(snr_pkg::OP_QUAD_IO, 1'b1, 1'b0, 2173, 5);
    run(snr_pkg::OP_DUAL_IO4, 1'b1, 1'b0, 2175, 2);
    rnd = pages;
    run(snr_pkg::OP_QUAD_IO, 1'b0, 1'b0, 0, 2180);
    chk(8'(pages - int'(rnd)), 8'h01);
    conclude();
  end

  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
endmodule // snr_fast_read_test

`default_nettype wire
